// ### design/ptm_pkg.sv
package ptm_pkg;
  // Register indices (byte-wide registers on a plain port)
  localparam logic [2:0] REG_CTRL0  = 3'h0;
  localparam logic [2:0] REG_CTRL1  = 3'h1;
  localparam logic [2:0] REG_CNT_LO = 3'h2;
  localparam logic [2:0] REG_CNT_HI = 3'h3;
  localparam logic [2:0] REG_CMPA_LO = 3'h4;
  localparam logic [2:0] REG_CMPA_HI = 3'h5;
  localparam logic [2:0] REG_CMPP_LO = 3'h6;
  localparam logic [2:0] REG_CMPP_HI = 3'h7;
  localparam logic [2:0] REG_FLAGS  = 3'h0;
  localparam logic [3:0] REG_FLAGS_ADDR = 4'h8;

  // Control 0 fields
  localparam int CTRL0_PAUSE = 7;
  localparam int CTRL0_CKS_HI = 6;
  localparam int CTRL0_CKS_LO = 4;
  localparam int CTRL0_ON = 3;
  localparam logic [7:0] CTRL0_MASK = 8'hf8;
  // Control 1 fields
  localparam int CTRL1_MODE_HI = 7;
  localparam int CTRL1_MODE_LO = 6;
  localparam int CTRL1_IO_HI = 5;
  localparam int CTRL1_IO_LO = 4;
  localparam int CTRL1_OC = 3;
  localparam int CTRL1_POL = 2;
  localparam int CTRL1_CAPTS = 1;
  localparam int CTRL1_CCLR = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Modes
  localparam logic [1:0] MODE_CMP = 2'h0;
  localparam logic [1:0] MODE_CAP = 2'h1;
  localparam logic [1:0] MODE_PWM = 2'h2;
  localparam logic [1:0] MODE_TMR = 2'h3;
  // Output function codes
  localparam logic [1:0] IO_00 = 2'h0;
  localparam logic [1:0] IO_01 = 2'h1;
  localparam logic [1:0] IO_10 = 2'h2;
  localparam logic [1:0] IO_11 = 2'h3;
  // Clock sources
  localparam logic [2:0] CKS_SYS4 = 3'h0;
  localparam logic [2:0] CKS_SYS  = 3'h1;
  localparam logic [2:0] CKS_H16  = 3'h2;
  localparam logic [2:0] CKS_H64  = 3'h3;
  localparam logic [2:0] CKS_TB0  = 3'h4;
  localparam logic [2:0] CKS_TB1  = 3'h5;
  localparam logic [2:0] CKS_XR   = 3'h6;
  localparam logic [2:0] CKS_XF   = 3'h7;
  localparam int DIV_SYS = 4;
  localparam int DIV_H16 = 16;
  localparam int DIV_H64 = 64;
endpackage

// ### design/ptm_timer.sv
// Contract
// - 10-bit up-counter on selected clock
// - Comparators A and P watch counter
// - Counter not writable; cleared by timer_on rise or auto clear
// - Auto clear on overflow or match
// - Pause holds count, resume continues
// - Three-bit select picks counter clock
// - timer_on runs; off keeps residue
// - timer_on rise restores initial level in compare mode, inactive level in PWM mode
// - Two-bit select picks operating mode
// - Compare mode: A match acts on pin
// - PWM mode: force, PWM or pulse
// - Capture mode: select trigger edge
// - Same level as initial: no change
// - Initial level or active level bit
// - Invert bit inverts output pin outside timer mode
// - Capture trigger from pin or clock
// - Clear on A, else P or overflow
// - Clear select ignored outside compare and timer modes
// - Control 0 low bits read zero
// - Counter and compares via register pairs
// - Zero compare A: overflow, no flag
// - Compare mode: P match flags only, pin unchanged
module ptm_timer
  import ptm_pkg::*;
#(
  parameter int CNT_W = 10
) (
  // Clock, reset, enable
  input  wire logic             REF_CLK_I,
  input  wire logic             SYS_RST_I,
  input  wire logic             CLK_EN_I,
  // Register port
  input  wire logic [3:0]       REG_ADDR_I,
  input  wire logic [7:0]       REG_WDATA_I,
  input  wire logic             REG_WR_I,
  input  wire logic             REG_RD_I,
  output logic      [7:0]       REG_RDATA_O,
  // Clock sources
  input  wire logic             HS_CLK_TICK_I,
  input  wire logic             TB_CLK_TICK_I,
  // Pins
  input  wire logic             EXT_CLK_I,
  input  wire logic             CAP_PIN_I,
  output logic                  TMR_OUT_O,
  // Events
  output logic                  CMP_A_FLAG_O,
  output logic                  CMP_P_FLAG_O,
  output logic      [CNT_W-1:0] CAPTURE_O
);

  typedef struct packed {
    logic [7:0]       ctrl0;
    logic [7:0]       ctrl1;
    logic [CNT_W-1:0] cmp_a;
    logic [CNT_W-1:0] cmp_p;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] cap;
    logic [5:0]       pre_sys;
    logic [5:0]       pre_hs;
    logic [1:0]       xclk_s;
    logic             xclk_d;
    logic [1:0]       cap_s;
    logic             cap_d;
    logic             on_d;
    logic             pin;
    logic             pulse_done;
    logic             flag_a;
    logic             flag_p;
    logic [7:0]       rdata;
    logic             out;
  } ptm_state_t;

  ptm_state_t r;
  ptm_state_t next_r;

  // Register read decode, used by the read path
  function automatic logic [7:0] rd_mux(input ptm_state_t s, input logic [3:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == REG_FLAGS_ADDR) begin
      v = {6'h00, s.flag_p, s.flag_a};
    end else begin
      case (a[2:0])
        REG_CTRL0:   v = s.ctrl0 & CTRL0_MASK;
        REG_CTRL1:   v = s.ctrl1;
        REG_CNT_LO:  v = s.cnt[7:0];
        REG_CNT_HI:  v = {6'h00, s.cnt[CNT_W-1:8]};
        REG_CMPA_LO: v = s.cmp_a[7:0];
        REG_CMPA_HI: v = {6'h00, s.cmp_a[CNT_W-1:8]};
        REG_CMPP_LO: v = s.cmp_p[7:0];
        REG_CMPP_HI: v = {6'h00, s.cmp_p[CNT_W-1:8]};
        default:     v = 8'h00;
      endcase
      if (a[3]) v = 8'h00;
    end
    return v;
  endfunction

  logic [2:0] cks;
  logic [1:0] mode;
  logic [1:0] iofn;
  logic       oc;
  logic       tick;
  logic       x_rise;
  logic       x_fall;
  logic       c_rise;
  logic       c_fall;
  logic       cap_trig;
  logic       match_a;
  logic       match_p;
  logic       ovf;
  logic       clr;
  logic       on_rise;
  logic       running;
  logic       active;

  always_comb begin
    cks  = r.ctrl0[CTRL0_CKS_HI:CTRL0_CKS_LO];
    mode = r.ctrl1[CTRL1_MODE_HI:CTRL1_MODE_LO];
    iofn = r.ctrl1[CTRL1_IO_HI:CTRL1_IO_LO];
    oc   = r.ctrl1[CTRL1_OC];
  end

  // Edge detect on second synchroniser stage only
  always_comb begin
    x_rise = r.xclk_s[1] & ~r.xclk_d;
    x_fall = ~r.xclk_s[1] & r.xclk_d;
    c_rise = r.cap_s[1] & ~r.cap_d;
    c_fall = ~r.cap_s[1] & r.cap_d;
  end

  // Counter clock selection
  // Prescalers run free, so the first divided tick lands anywhere in its period
  always_comb begin
    case (cks)
      CKS_SYS4: tick = (r.pre_sys[1:0] == 2'(DIV_SYS - 1));
      CKS_SYS:  tick = 1'b1;
      CKS_H16:  tick = HS_CLK_TICK_I && (r.pre_hs[3:0] == 4'(DIV_H16 - 1));
      CKS_H64:  tick = HS_CLK_TICK_I && (r.pre_hs == 6'(DIV_H64 - 1));
      CKS_TB0:  tick = TB_CLK_TICK_I;
      CKS_TB1:  tick = TB_CLK_TICK_I;
      CKS_XR:   tick = x_rise;
      CKS_XF:   tick = x_fall;
      default:  tick = 1'b0;
    endcase
  end

  // Comparators and clear conditions
  always_comb begin
    on_rise = r.ctrl0[CTRL0_ON] & ~r.on_d;
    running = r.ctrl0[CTRL0_ON] & ~r.ctrl0[CTRL0_PAUSE] & ~on_rise;
    active  = running & tick;
    ovf     = (r.cnt == {CNT_W{1'b1}});
    // A zero compare A never matches; overflow covers that case
    match_a = active && (r.cmp_a != '0) && (r.cnt == r.cmp_a - 1'b1) ;
    match_p = active && (r.cmp_p != '0) && (r.cnt == r.cmp_p - 1'b1);
    if (mode == MODE_CMP || mode == MODE_TMR) begin
      if (r.ctrl1[CTRL1_CCLR]) clr = match_a | (active & ovf);
      else clr = match_p | (active & ovf);
    end else begin
      clr = match_p | (active & ovf);
    end
  end

  // Capture trigger selection
  always_comb begin
    logic rs;
    logic fs;
    rs = r.ctrl1[CTRL1_CAPTS] ? x_rise : c_rise;
    fs = r.ctrl1[CTRL1_CAPTS] ? x_fall : c_fall;
    case (iofn)
      IO_00:   cap_trig = rs;
      IO_01:   cap_trig = fs;
      IO_10:   cap_trig = rs | fs;
      default: cap_trig = 1'b0;
    endcase
    // A stopped timer ignores the pins, so stale edges never capture
    if (mode != MODE_CAP || !r.ctrl0[CTRL0_ON]) cap_trig = 1'b0;
  end

  // Next state
  always_comb begin
    logic pa;
    logic duty;
    duty = 1'b0;
    next_r = r;
    next_r.xclk_s = {r.xclk_s[0], EXT_CLK_I};
    next_r.xclk_d = r.xclk_s[1];
    next_r.cap_s  = {r.cap_s[0], CAP_PIN_I};
    next_r.cap_d  = r.cap_s[1];
    next_r.on_d   = r.ctrl0[CTRL0_ON];
    next_r.pre_sys = r.pre_sys + 6'h01;
    if (HS_CLK_TICK_I) next_r.pre_hs = r.pre_hs + 6'h01;
    next_r.flag_a = 1'b0;
    next_r.flag_p = 1'b0;
    pa = 1'b0;
    // Counter: no software write path; on-rise or the auto clear zeroes it
    if (on_rise) begin
      next_r.cnt = '0;
      next_r.pulse_done = 1'b0;
    end else if (active) begin
      next_r.cnt = clr ? '0 : r.cnt + 1'b1;
    end
    // Match flags: P suppressed when A clears the counter
    if (match_a) begin
      next_r.flag_a = 1'b1;
    end
    if (match_p && !((mode == MODE_CMP || mode == MODE_TMR) && r.ctrl1[CTRL1_CCLR])) begin
      next_r.flag_p = 1'b1;
    end
    // Capture sees the count before this cycle's step
    if (cap_trig) next_r.cap = r.cnt;
    // Output pin logic
    if (on_rise && mode != MODE_TMR && mode != MODE_CAP) begin
      next_r.pin = (mode == MODE_CMP) ? oc : 1'b0;
    end else if (mode == MODE_CMP && match_a) begin
      case (iofn)
        IO_01:   pa = 1'b0;
        IO_10:   pa = 1'b1;
        IO_11:   pa = ~r.pin;
        default: pa = r.pin;
      endcase
      next_r.pin = pa;
    end else if (mode == MODE_PWM) begin
      // Active while counter below compare A; pulse ends at first P match
      duty = (r.cnt < r.cmp_a);
      if (iofn == IO_11 && match_p) next_r.pulse_done = 1'b1;
      case (iofn)
        IO_00:   next_r.pin = 1'b0;
        IO_01:   next_r.pin = 1'b1;
        IO_10:   next_r.pin = r.ctrl0[CTRL0_ON] & duty;
        default: next_r.pin = r.ctrl0[CTRL0_ON] & ~r.pulse_done & ~match_p;
      endcase
    end
    // Pin level: PWM uses active-level select, then invert
    if (mode == MODE_PWM) begin
      next_r.out = (next_r.pin ~^ oc) ^ r.ctrl1[CTRL1_POL];
    end else if (mode == MODE_TMR) begin
      next_r.out = 1'b0;
    end else begin
      next_r.out = next_r.pin ^ r.ctrl1[CTRL1_POL];
    end
    // Register writes
    if (REG_WR_I && !REG_ADDR_I[3]) begin
      case (REG_ADDR_I[2:0])
        REG_CTRL0:   next_r.ctrl0 = REG_WDATA_I & CTRL0_MASK;
        REG_CTRL1:   next_r.ctrl1 = REG_WDATA_I;
        REG_CMPA_LO: next_r.cmp_a[7:0] = REG_WDATA_I;
        REG_CMPA_HI: next_r.cmp_a[CNT_W-1:8] = REG_WDATA_I[1:0];
        REG_CMPP_LO: next_r.cmp_p[7:0] = REG_WDATA_I;
        REG_CMPP_HI: next_r.cmp_p[CNT_W-1:8] = REG_WDATA_I[1:0];
        default:     next_r.ctrl0 = r.ctrl0;
      endcase
    end
    next_r.rdata = REG_RD_I ? rd_mux(r, REG_ADDR_I) : 8'h00;
  end

  // State register; enable freezes everything
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      r <= '0;
    end else if (CLK_EN_I) begin
      r <= next_r;
    end
  end

  always_comb begin
    REG_RDATA_O  = r.rdata;
    TMR_OUT_O    = r.out;
    CMP_A_FLAG_O = r.flag_a;
    CMP_P_FLAG_O = r.flag_p;
    CAPTURE_O    = r.cap;
  end

  // Rising timer_on clears counter
  on_clear_a: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
    CLK_EN_I && on_rise |=> r.cnt == '0)
    else $error("counter not cleared on timer_on rise");
  // Pause holds count
  pause_hold_a: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
    CLK_EN_I && r.ctrl0[CTRL0_PAUSE] && !on_rise |=> $stable(r.cnt))
    else $error("counter moved while paused");
  // Off keeps residue
  off_hold_a: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
    CLK_EN_I && !r.ctrl0[CTRL0_ON] |=> $stable(r.cnt))
    else $error("counter moved while off");
  // Zero compare A gives no flag
  zero_a_a: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
    CLK_EN_I && r.cmp_a == '0 |=> !r.flag_a)
    else $error("flag A with zero compare");
  // P match never moves pin in compare mode
  p_pin_a: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
    CLK_EN_I && mode == MODE_CMP && match_p && !match_a && !on_rise
    && $stable(r.ctrl1) |=> $stable(r.pin))
    else $error("pin moved on P match");
  // Clear on A with clear select set
  clr_a_a: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
    CLK_EN_I && mode == MODE_CMP && r.ctrl1[CTRL1_CCLR] && match_a && !on_rise
    |=> r.cnt == '0 && r.flag_a)
    else $error("no clear on A match");
  // Initial level restored
  init_lvl_a: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
    CLK_EN_I && on_rise && mode == MODE_CMP |=> r.pin == $past(oc))
    else $error("initial level not restored");
  // Low control bits read zero
  rd_zero_a: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
    CLK_EN_I && REG_RD_I && REG_ADDR_I == {1'b0, REG_CTRL0} |=> REG_RDATA_O[2:0] == 3'h0)
    else $error("reserved bits nonzero");

  // Frozen enable keeps every state bit
  freeze_hold_a: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
    !CLK_EN_I |=> $stable(r))
    else $error("state moved while enable low");

  // Count step: a tick while running, no clear due
  sequence cnt_step_s;
    CLK_EN_I && running && tick && !clr;
  endsequence
  // Pin step: the selected external edge while running
  sequence ext_step_s;
    CLK_EN_I && running && !clr
    && ((cks == CKS_XR && x_rise) || (cks == CKS_XF && x_fall));
  endsequence

  // Each tick adds exactly one
  cnt_step_a: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
    cnt_step_s |=> r.cnt == $past(r.cnt) + 1'b1)
    else $error("count did not advance on tick");
  // Synchronised pin edge adds exactly one
  ext_sync_a: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
    ext_step_s |=> r.cnt == $past(r.cnt) + 1'b1)
    else $error("count did not follow pin edge");

  // Overflow wraps to zero
  ovf_wrap_a: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
    CLK_EN_I && active && ovf |=> r.cnt == '0)
    else $error("no wrap on overflow");
  // A match always raises its flag
  flag_a_a: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
    CLK_EN_I && match_a |=> r.flag_a)
    else $error("no flag on A match");

  // Clear on A suppresses the P flag
  no_p_cclr_a: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
    CLK_EN_I && (mode == MODE_CMP || mode == MODE_TMR) && r.ctrl1[CTRL1_CCLR] |=> !r.flag_p)
    else $error("P flag while clearing on A");
  // Timer/counter mode parks the pin low
  tmr_pin_a: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
    CLK_EN_I && mode == MODE_TMR |=> !TMR_OUT_O)
    else $error("pin driven in timer mode");

  // Capture takes the count of the trigger cycle
  cap_grab_a: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
    CLK_EN_I && cap_trig |=> r.cap == $past(r.cnt))
    else $error("capture lost the count");
  // Disabled capture keeps the last value
  cap_off_a: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
    CLK_EN_I && mode == MODE_CAP && iofn == IO_11 |=> $stable(r.cap))
    else $error("capture moved while disabled");

  // Single pulse stays ended until the next turn-on
  pulse_end_a: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
    CLK_EN_I && mode == MODE_PWM && iofn == IO_11 && r.pulse_done && !on_rise |=> !r.pin)
    else $error("pulse restarted");
  // PWM level follows count against compare A
  pwm_duty_a: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
    CLK_EN_I && mode == MODE_PWM && iofn == IO_10 && r.ctrl0[CTRL0_ON] && !on_rise
    |=> TMR_OUT_O == ((($past(r.cnt) < $past(r.cmp_a)) ~^ $past(oc))
                      ^ $past(r.ctrl1[CTRL1_POL])))
    else $error("PWM level off its duty");
endmodule

// ### testbench/ptm_pins_model.sv
// Far-side pins: external clock bursts and a quiet capture pin
module ptm_pins_model (
  // Bench control
  input  wire logic       clk_i,
  input  wire logic       start_i,
  input  wire logic [7:0] n_edges_i,
  // Pins
  output logic            ext_clk_o = 1'b0,
  output logic            cap_pin_o,
  output logic            busy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] half = 5'h00;
  logic [7:0] left = 8'h00;
  assign cap_pin_o = 1'b0;
  assign busy_o = (left != 8'h00);
  // Slow pin clock, idle low between bursts so no stray edge reaches the timer
  always @(posedge clk_i) begin
    if (start_i) begin
      left <= n_edges_i;
      half <= 5'h00;
      ext_clk_o <= 1'b0;
    end else if (left != 8'h00) begin
      half <= half + 5'h01;
      if (half == 5'h02) begin
        half <= 5'h00;
        ext_clk_o <= ~ext_clk_o;
        if (ext_clk_o) left <= left - 8'h01;
      end
    end
  end
endmodule

// ### testbench/tb.sv
`define CHK(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin bad_count++; $display("mismatch %s expected %h seen %h", what, exp, got); end end
module tb;
  import ptm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // Bench-driven inputs
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       tick = 1'b0;
  logic       start = 1'b0;
  logic [7:0] n_edges = 8'h00;
  logic       en = 1'b1;
  logic [9:0] cap_val;
  // Observed
  logic [7:0] rdata;
  logic       ext_clk;
  logic       cap_pin;
  logic       busy;
  logic       tmr_out;
  logic       flag_a;
  logic       flag_p;
  int         bad_count = 0;
  int         n_compared = 0;
  logic [7:0] d;
  int         n;

  ptm_timer dut_u (
    .REF_CLK_I(clk), .SYS_RST_I(rst), .CLK_EN_I(en),
    .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd),
    .REG_RDATA_O(rdata), .HS_CLK_TICK_I(tick), .TB_CLK_TICK_I(tick),
    .EXT_CLK_I(ext_clk), .CAP_PIN_I(cap_pin), .TMR_OUT_O(tmr_out),
    .CMP_A_FLAG_O(flag_a), .CMP_P_FLAG_O(flag_p), .CAPTURE_O(cap_val)
  );
  ptm_pins_model pins_u (
    .clk_i(clk), .start_i(start), .n_edges_i(n_edges),
    .ext_clk_o(ext_clk), .cap_pin_o(cap_pin), .busy_o(busy)
  );

  // 25 MHz clock and a divided tick for the slower sources
  initial forever #20 clk = ~clk;
  always @(posedge clk) tick <= ~tick;

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= {1'b0, a};
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data is valid only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask

  task automatic wait_flag(input logic use_p, output int cycles);
    cycles = 0;
    do begin
      @(posedge clk);
      #1;
      cycles++;
    end while (((use_p ? flag_p : flag_a) !== 1'b1) && cycles < 2000);
    if (cycles >= 2000) begin
      bad_count++;
      print_verdict();
    end
  endtask

  task automatic check_regs();
    rd_reg({1'b0, REG_CTRL1}, d);
    `CHK("ctrl1_reset", 8'h00, d)
    wr_reg(REG_CTRL0, 8'hf7);
    rd_reg({1'b0, REG_CTRL0}, d);
    `CHK("ctrl0_low_bits", 8'hf0, d)
    wr_reg(REG_CTRL0, 8'h00);
    wr_reg(REG_CMPA_HI, 8'hff);
    rd_reg({1'b0, REG_CMPA_HI}, d);
    `CHK("cmpa_high", 8'h03, d)
    wr_reg(REG_CNT_LO, 8'h55);
    rd_reg({1'b0, REG_CNT_LO}, d);
    `CHK("count_not_writable", 8'h00, d)
    rd_reg(4'hf, d);
    `CHK("unmapped", 8'h00, d)
  endtask

  // Each entry: {io, initial level, invert, pin at start, pin after A}
  task automatic check_out_modes();
    logic [5:0] t [5] = '{6'b110001, 6'b011101, 6'b010000, 6'b001011, 6'b100110};
    wr_reg(REG_CMPA_LO, 8'h05);
    wr_reg(REG_CMPA_HI, 8'h00);
    foreach (t[i]) begin
      wr_reg(REG_CTRL0, 8'h00);
      wr_reg(REG_CTRL1, {MODE_CMP, t[i][5:2], 2'b01});
      wr_reg(REG_CTRL0, {1'b0, CKS_SYS, 4'h8});
      repeat (3) @(posedge clk);
      #1;
      `CHK("pin_initial", t[i][1], tmr_out)
      wait_flag(1'b0, n);
      repeat (2) @(posedge clk);
      #1;
      `CHK("pin_after_a", t[i][0], tmr_out)
      wait_flag(1'b0, n);
      `CHK("a_period_rest", 3, n)
    end
  endtask

  // P clears when clear select is low; zero compare A never flags
  task automatic check_period_p();
    wr_reg(REG_CTRL0, 8'h00);
    wr_reg(REG_CTRL1, {MODE_CMP, IO_00, 4'h0});
    wr_reg(REG_CMPA_LO, 8'h00);
    wr_reg(REG_CMPP_LO, 8'h07);
    wr_reg(REG_CTRL0, {1'b0, CKS_SYS, 4'h8});
    wait_flag(1'b1, n);
    wait_flag(1'b1, n);
    `CHK("p_period", 7, n)
    n = 0;
    repeat (20) begin
      @(posedge clk);
      #1;
      if (flag_a !== 1'b0) n++;
    end
    `CHK("no_a_flag", 0, n)
  endtask

  task automatic check_pause_on();
    logic [7:0] held;
    wr_reg(REG_CTRL0, {1'b1, CKS_SYS, 4'h8});
    rd_reg({1'b0, REG_CNT_LO}, held);
    repeat (10) @(posedge clk);
    rd_reg({1'b0, REG_CNT_LO}, d);
    `CHK("paused_count", held, d)
    wr_reg(REG_CTRL0, {1'b1, CKS_SYS, 4'h0});
    wr_reg(REG_CTRL0, {1'b1, CKS_SYS, 4'h8});
    rd_reg({1'b0, REG_CNT_LO}, d);
    `CHK("count_cleared_on_rise", 8'h00, d)
  endtask

  // Six pin clock periods, then time for the synchroniser to settle
  task automatic pin_burst();
    @(posedge clk);
    start <= 1'b1;
    n_edges <= 8'h06;
    @(posedge clk);
    start <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (busy && n < 200);
    if (n >= 200) begin
      bad_count++;
      print_verdict();
    end
    repeat (4) @(posedge clk);
  endtask

  // Six pin edges of the chosen sense must give a count of six
  task automatic check_ext_clock();
    logic [2:0] src [2] = '{CKS_XR, CKS_XF};
    wr_reg(REG_CTRL0, 8'h00);
    wr_reg(REG_CTRL1, {MODE_TMR, 6'h00});
    wr_reg(REG_CMPP_LO, 8'h00);
    foreach (src[i]) begin
      wr_reg(REG_CTRL0, 8'h00);
      wr_reg(REG_CTRL0, {1'b0, src[i], 4'h8});
      pin_burst();
      rd_reg({1'b0, REG_CNT_LO}, d);
      `CHK("ext_count", 8'h06, d)
    end
  endtask

  // Pin edges as capture triggers: a rise keeps the count before its step
  task automatic check_capture();
    logic [5:0] t [3] = '{{IO_00, 4'h5}, {IO_11, 4'h5}, {IO_01, 4'h6}};
    foreach (t[i]) begin
      wr_reg(REG_CTRL0, 8'h00);
      wr_reg(REG_CTRL1, {MODE_CAP, t[i][5:4], 4'h2});
      wr_reg(REG_CTRL0, {1'b0, CKS_XR, 4'h8});
      pin_burst();
      `CHK("capture", {6'h00, t[i][3:0]}, cap_val)
    end
  endtask

  // Highs over two periods of eight; compare A sets a duty of three
  task automatic check_pwm();
    logic [8:0] t [5] = '{{IO_10, 2'h2, 5'h06}, {IO_10, 2'h0, 5'h0a}, {IO_10, 2'h3, 5'h0a},
                          {IO_11, 2'h2, 5'h00}, {IO_01, 2'h2, 5'h10}};
    wr_reg(REG_CTRL0, 8'h00);
    wr_reg(REG_CMPA_LO, 8'h03);
    wr_reg(REG_CMPP_LO, 8'h08);
    foreach (t[i]) begin
      wr_reg(REG_CTRL0, 8'h00);
      wr_reg(REG_CTRL1, {MODE_PWM, t[i][8:5], 2'h0});
      wr_reg(REG_CTRL0, {1'b0, CKS_SYS, 4'h8});
      wait_flag(1'b1, n);
      n = 0;
      repeat (16) begin
        @(posedge clk);
        #1;
        if (tmr_out === 1'b1) n++;
      end
      `CHK("pwm_highs", t[i][4:0], 5'(n))
    end
  endtask

  // Counts over 64 cycles per source; the last entry freezes 20 of them
  task automatic check_sources();
    logic [10:0] t [5] = '{{CKS_SYS4, 8'h10}, {CKS_H16, 8'h02}, {CKS_TB0, 8'h20},
                           {CKS_TB1, 8'h20}, {CKS_SYS, 8'h2c}};
    logic [7:0]  held;
    wr_reg(REG_CTRL0, 8'h00);
    wr_reg(REG_CTRL1, {MODE_TMR, 6'h00});
    wr_reg(REG_CMPP_LO, 8'h00);
    wr_reg(REG_CTRL0, {1'b0, CKS_SYS, 4'h8});
    foreach (t[i]) begin
      wr_reg(REG_CTRL0, {1'b0, t[i][10:8], 4'h8});
      rd_reg({1'b0, REG_CNT_LO}, held);
      repeat (21) @(posedge clk);
      en <= (t[i][10:8] != CKS_SYS);
      repeat (20) @(posedge clk);
      en <= 1'b1;
      repeat (21) @(posedge clk);
      rd_reg({1'b0, REG_CNT_LO}, d);
      `CHK("src_count", t[i][7:0], 8'(d - held))
    end
  endtask

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    check_regs();
    check_out_modes();
    check_period_p();
    check_pause_on();
    check_ext_clock();
    check_capture();
    check_pwm();
    check_sources();
    print_verdict();
  end
endmodule
